// ---- include/dbg_port_pkg.sv ----
// constants, types and decoders for the debug port control and status registers
`default_nettype none
package dbg_port_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_REVISION = 4'h0;
  localparam logic [3:0] OFS_ERROR = 4'h1;
  localparam logic [3:0] OFS_LINK_CTRL = 4'h2;
  localparam logic [3:0] OFS_LINK_OPT = 4'h3;
  localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
  localparam logic [3:0] OFS_RESET_REQ = 4'h8;
  localparam logic [3:0] OFS_CLK_SEL = 4'h9;
  localparam logic [3:0] OFS_SYS_CTRL = 4'hA;
  localparam logic [3:0] OFS_SYS_STATUS = 4'hB;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int POS_IBD = 7;
  localparam int POS_PARITY_DIS = 5;
  localparam int POS_TIMEOUT_DIS = 4;
  localparam int POS_RESP_DIS = 3;
  localparam int POS_NACK_DIS = 4;
  localparam int POS_CONT_DIS = 3;
  localparam int POS_PORT_DIS = 2;
  localparam int POS_KEY_UROW = 5;
  localparam int POS_KEY_PROG = 4;
  localparam int POS_KEY_ERASE = 3;
  localparam int POS_UROW_DONE = 1;
  localparam int POS_CLK_REQ = 0;

  // ----------------------------------------
  // reset values and codes
  // ----------------------------------------
  localparam logic [1:0] RST_CLK_SEL = 2'h3;
  localparam logic [4:0] RST_SYS_STATE = 5'h01;
  localparam logic [7:0] RESET_CODE = 8'h59;
  localparam logic [7:0] RUN_CODE = 8'h00;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_PARITY = 3'h1;
  localparam logic [2:0] ERR_FRAME = 3'h2;
  localparam logic [2:0] ERR_TIMEOUT = 3'h3;
  localparam logic [2:0] ERR_CLOCK = 3'h4;
  localparam logic [2:0] ERR_BUS = 3'h6;
  localparam logic [2:0] ERR_CONTENTION = 3'h7;
  localparam int TIMEOUT_CYCLES = 65536;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic inter_byte_delay_enable;
    logic parity_check_disable;
    logic timeout_detect_disable;
    logic response_signature_disable;
    logic [2:0] guard_time_select;
    logic negative_ack_disable;
    logic contention_detect_disable;
  } link_cfg_s;

  typedef struct packed {
    logic parity;
    logic frame;
    logic clock_recovery;
    logic bus;
    logic contention;
  } phy_err_s;

  // order matters: matches RST_SYS_STATE, lock flag in bit 0
  typedef struct packed {
    logic system_reset_active;
    logic system_in_sleep;
    logic memory_program_start;
    logic user_row_program_start;
    logic device_lock_flag;
  } sys_state_s;

  // code 7 is reserved; it falls back to the longest guard time
  function automatic logic [7:0] guard_cycles(input logic [2:0] sel);
    guard_cycles = (sel == 3'h7) ? 8'h80 : (8'h80 >> sel);
  endfunction

endpackage
`default_nettype wire

// ---- logic/timeout_watch.sv ----
// access layer response time-out watchdog
`timescale 1ns/1ps
`default_nettype none
module timeout_watch #(
  parameter int CYCLES = 65536
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic waiting,
  input wire logic detect_disable,
  output logic expired_q
);

  localparam int W = $clog2(CYCLES);

  logic [W-1:0] count_q;
  logic fired_q;

  // fires once per wait; a new wait must drop and rise again
  always_ff @(posedge ref_clk)
  begin
    if (reset || !waiting || detect_disable)
    begin
      count_q <= '0;
      fired_q <= 1'b0;
      expired_q <= 1'b0;
    end
    else
    begin
      expired_q <= 1'b0;
      if (!fired_q)
      begin
        count_q <= count_q + 1'b1;
        if (count_q == W'(CYCLES - 1))
        begin
          expired_q <= 1'b1;
          fired_q <= 1'b1;
        end
      end
    end
  end

  expire_count_a: assert property (@(posedge ref_clk) disable iff (reset)
    expired_q |-> $past(count_q) == W'(CYCLES - 1) && $past(waiting) && !$past(detect_disable))
    else $error("time-out fired at wrong count");

endmodule
`default_nettype wire

// ---- logic/debug_port_control_status.sv ----
// control and status register set of the single-wire debug port
`timescale 1ns/1ps
`default_nettype none
module debug_port_control_status #(
  parameter logic [3:0] PORT_REVISION = 4'h1, // arbitrary value
  parameter int TIMEOUT_CYCLES = dbg_port_pkg::TIMEOUT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire dbg_port_pkg::phy_err_s phy_err,
  input wire logic access_waiting,
  input wire logic key_urow_hit,
  input wire logic key_prog_hit,
  input wire logic key_erase_hit,
  input wire logic port_enable,
  input wire dbg_port_pkg::sys_state_s sys_state,
  output logic [7:0] reg_rdata_q,
  output dbg_port_pkg::link_cfg_s link_cfg_q,
  output logic [7:0] guard_cycles_q,
  output logic port_shutdown_q,
  output logic access_timeout_q,
  output logic [1:0] clock_select_q,
  output logic system_clock_request_q,
  output logic system_reset_q,
  output logic user_row_program_q
);

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  // only the port instruction path reaches here; no cpu port exists
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_opt, wr_key, wr_rst, wr_sys, rd_err, port_off;
  assign wr_opt = reg_wr && hit(reg_addr, dbg_port_pkg::OFS_LINK_OPT);
  assign wr_key = reg_wr && hit(reg_addr, dbg_port_pkg::OFS_KEY_STATUS);
  assign wr_rst = reg_wr && hit(reg_addr, dbg_port_pkg::OFS_RESET_REQ);
  assign wr_sys = reg_wr && hit(reg_addr, dbg_port_pkg::OFS_SYS_CTRL);
  assign rd_err = reg_rd && hit(reg_addr, dbg_port_pkg::OFS_ERROR);
  assign port_off = wr_opt && reg_wdata[dbg_port_pkg::POS_PORT_DIS];

  // ----------------------------------------
  // system state synchroniser
  // ----------------------------------------
  logic [4:0] sys_s1_q, sys_s2_q, sys_s3_q;
  dbg_port_pkg::sys_state_s sys_q;
  logic prog_start_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk)
      begin
        if (reset)
        begin
          sys_s1_q[gi] <= dbg_port_pkg::RST_SYS_STATE[gi];
          sys_s2_q[gi] <= dbg_port_pkg::RST_SYS_STATE[gi];
          sys_s3_q[gi] <= dbg_port_pkg::RST_SYS_STATE[gi];
          sys_q[gi] <= dbg_port_pkg::RST_SYS_STATE[gi];
        end
        else
        begin
          sys_s1_q[gi] <= sys_state[gi];
          sys_s2_q[gi] <= sys_s1_q[gi];
          sys_s3_q[gi] <= sys_s2_q[gi];
          if (sys_s2_q[gi] == sys_s3_q[gi])
            sys_q[gi] <= sys_s3_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      prog_start_prev_q <= 1'b0;
    else
      prog_start_prev_q <= sys_q.memory_program_start;
  end

  // ----------------------------------------
  // error signature
  // ----------------------------------------
  logic [2:0] err_sig_q, event_code;

  // masked sources never reach the code, so they cannot raise it
  always_comb
  begin
    event_code = dbg_port_pkg::ERR_NONE;
    if (phy_err.contention && !link_cfg_q.contention_detect_disable)
      event_code = dbg_port_pkg::ERR_CONTENTION;
    else if (phy_err.bus)
      event_code = dbg_port_pkg::ERR_BUS;
    else if (phy_err.clock_recovery)
      event_code = dbg_port_pkg::ERR_CLOCK;
    else if (access_timeout_q)
      event_code = dbg_port_pkg::ERR_TIMEOUT;
    else if (phy_err.frame)
      event_code = dbg_port_pkg::ERR_FRAME;
    else if (phy_err.parity && !link_cfg_q.parity_check_disable)
      event_code = dbg_port_pkg::ERR_PARITY;
  end

  // a new error in the read cycle wins over the clear
  always_ff @(posedge ref_clk)
  begin
    if (reset || port_off)
      err_sig_q <= dbg_port_pkg::ERR_NONE;
    else if (event_code != dbg_port_pkg::ERR_NONE)
      err_sig_q <= event_code;
    else if (rd_err)
      err_sig_q <= dbg_port_pkg::ERR_NONE;
  end

  timeout_watch #(
    .CYCLES(TIMEOUT_CYCLES)
  ) u_timeout (
    .ref_clk(ref_clk),
    .reset(reset || port_off),
    .waiting(access_waiting),
    .detect_disable(link_cfg_q.timeout_detect_disable),
    .expired_q(access_timeout_q)
  );

  // ----------------------------------------
  // link configuration
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset || port_off)
      link_cfg_q <= '0;
    else if (reg_wr && hit(reg_addr, dbg_port_pkg::OFS_LINK_CTRL))
    begin
      link_cfg_q.inter_byte_delay_enable <= reg_wdata[dbg_port_pkg::POS_IBD];
      link_cfg_q.parity_check_disable <= reg_wdata[dbg_port_pkg::POS_PARITY_DIS];
      link_cfg_q.timeout_detect_disable <= reg_wdata[dbg_port_pkg::POS_TIMEOUT_DIS];
      link_cfg_q.response_signature_disable <= reg_wdata[dbg_port_pkg::POS_RESP_DIS];
      link_cfg_q.guard_time_select <= reg_wdata[2:0];
    end
    else if (wr_opt)
    begin
      link_cfg_q.negative_ack_disable <= reg_wdata[dbg_port_pkg::POS_NACK_DIS];
      link_cfg_q.contention_detect_disable <= reg_wdata[dbg_port_pkg::POS_CONT_DIS];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      guard_cycles_q <= dbg_port_pkg::guard_cycles(3'h0);
    else
      guard_cycles_q <= dbg_port_pkg::guard_cycles(link_cfg_q.guard_time_select);
  end

  // shutdown is a one-cycle notice to the physical layer
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      port_shutdown_q <= 1'b0;
    else
      port_shutdown_q <= port_off;
  end

  // ----------------------------------------
  // key status
  // ----------------------------------------
  logic urow_key_q, prog_key_q, erase_key_q;

  always_ff @(posedge ref_clk)
  begin
    if (reset || port_off)
    begin
      urow_key_q <= 1'b0;
      prog_key_q <= 1'b0;
      erase_key_q <= 1'b0;
    end
    else
    begin
      // writing the bit ends the user-row session
      if (key_urow_hit)
        urow_key_q <= 1'b1;
      else if (wr_key && reg_wdata[dbg_port_pkg::POS_KEY_UROW])
        urow_key_q <= 1'b0;
      if (key_prog_hit)
        prog_key_q <= 1'b1;
      else if (sys_q.memory_program_start && !prog_start_prev_q)
        prog_key_q <= 1'b0;
      if (key_erase_hit)
        erase_key_q <= 1'b1;
      else if (wr_rst && reg_wdata == dbg_port_pkg::RESET_CODE)
        erase_key_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // system interface control
  // ----------------------------------------
  logic [7:0] reset_req_q;

  // port disable leaves the system reset alone; it belongs to the system
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      reset_req_q <= dbg_port_pkg::RUN_CODE;
      system_reset_q <= 1'b0;
    end
    else if (wr_rst)
    begin
      reset_req_q <= reg_wdata;
      if (reg_wdata == dbg_port_pkg::RESET_CODE)
        system_reset_q <= 1'b1;
      else if (reg_wdata == dbg_port_pkg::RUN_CODE)
        system_reset_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset || port_off || port_enable)
      clock_select_q <= dbg_port_pkg::RST_CLK_SEL;
    else if (reg_wr && hit(reg_addr, dbg_port_pkg::OFS_CLK_SEL) && reg_wdata[1:0] != 2'h0)
      clock_select_q <= reg_wdata[1:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset || port_off)
      system_clock_request_q <= 1'b0;
    else if (port_enable)
      system_clock_request_q <= 1'b1;
    else if (wr_sys)
      system_clock_request_q <= reg_wdata[dbg_port_pkg::POS_CLK_REQ];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      user_row_program_q <= 1'b0;
    else
      user_row_program_q <= wr_sys && urow_key_q
        && reg_wdata[dbg_port_pkg::POS_UROW_DONE];
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] rd_value;

  always_comb
  begin
    rd_value = 8'h00;
    unique case (reg_addr)
      dbg_port_pkg::OFS_REVISION: rd_value = {PORT_REVISION, 4'h0};
      dbg_port_pkg::OFS_ERROR: rd_value = {5'h00, err_sig_q};
      dbg_port_pkg::OFS_LINK_CTRL: rd_value = {link_cfg_q.inter_byte_delay_enable, 1'b0,
        link_cfg_q.parity_check_disable, link_cfg_q.timeout_detect_disable,
        link_cfg_q.response_signature_disable, link_cfg_q.guard_time_select};
      dbg_port_pkg::OFS_LINK_OPT: rd_value = {3'h0, link_cfg_q.negative_ack_disable,
        link_cfg_q.contention_detect_disable, 3'h0};
      dbg_port_pkg::OFS_KEY_STATUS: rd_value = {2'h0, urow_key_q, prog_key_q,
        erase_key_q, 3'h0};
      dbg_port_pkg::OFS_RESET_REQ: rd_value = reset_req_q;
      dbg_port_pkg::OFS_CLK_SEL: rd_value = {6'h00, clock_select_q};
      dbg_port_pkg::OFS_SYS_CTRL: rd_value = {7'h00, system_clock_request_q};
      dbg_port_pkg::OFS_SYS_STATUS: rd_value = {2'h0,
        sys_q.system_reset_active || system_reset_q,
        sys_q.system_in_sleep,
        sys_q.memory_program_start, sys_q.user_row_program_start, 1'b0,
        sys_q.device_lock_flag};
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
      reg_rdata_q <= rd_value;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  err_load_a: assert property (
    event_code != 3'h0 && !port_off |=> err_sig_q == $past(event_code))
    else $error("error code not loaded");

  err_clear_a: assert property (
    rd_err && event_code == 3'h0 |=> err_sig_q == 3'h0)
    else $error("error code not cleared by read");

  parity_mask_a: assert property (
    link_cfg_q.parity_check_disable |-> event_code != 3'h1)
    else $error("parity error raised while disabled");

  contention_mask_a: assert property (
    link_cfg_q.contention_detect_disable |-> event_code != 3'h7)
    else $error("contention raised while disabled");

  reset_hold_a: assert property (
    wr_rst && reg_wdata == 8'h59 |=> system_reset_q ##1 (system_reset_q || $past(wr_rst)))
    else $error("system reset not held");

  reset_release_a: assert property (
    wr_rst && reg_wdata == 8'h00 |=> !system_reset_q)
    else $error("system reset not released");

  port_off_a: assert property (
    port_off |=> port_shutdown_q && !system_clock_request_q
      && clock_select_q == 2'h3 && link_cfg_q == '0 && !urow_key_q)
    else $error("port disable left state behind");

  urow_gate_a: assert property (
    user_row_program_q |-> $past(wr_sys) && $past(urow_key_q))
    else $error("user-row programming without key");

  guard_map_a: assert property (
    guard_cycles_q == (8'h80 >> $past(link_cfg_q.guard_time_select))
      || $past(link_cfg_q.guard_time_select) == 3'h7)
    else $error("guard time mismatch");

  erase_clear_a: assert property (
    wr_rst && reg_wdata == 8'h59 && !key_erase_hit |=> !erase_key_q)
    else $error("erase key survived reset request");

  cov_reset_cycle_c: cover property (wr_rst && reg_wdata == 8'h59 ##[1:20] !system_reset_q);
  cov_urow_c: cover property (key_urow_hit ##[1:20] user_row_program_q);
  cov_timeout_c: cover property (access_timeout_q);

endmodule
`default_nettype wire

// ---- sim/debugger_model.sv ----
// behavioural debugger issuing register instructions over the port
`timescale 1ns/1ps
`default_nettype none
module debugger_model (
  input wire logic ref_clk,
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q
);
  // idle cycles before each request, so the model can be prompt or slow
  int gap = 0;

  initial
  begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // released lines change pattern, so a stale value never looks valid
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  // the only way into the registers is this instruction port
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    repeat (gap + 1) @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    release_bus();
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    repeat (gap + 1) @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    release_bus();
    d = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

// ---- sim/debug_port_control_status_tb_top.sv ----
// self-checking bench for the debug port control and status registers
`timescale 1ns/1ps
`default_nettype none
module debug_port_control_status_tb_top;
  localparam logic [3:0] REV = 4'h1; // arbitrary value
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_q;
  dbg_port_pkg::phy_err_s phy_err = '0;
  logic access_waiting = 1'b0;
  logic [2:0] key_hit = 3'h0;
  logic port_enable = 1'b0;
  dbg_port_pkg::sys_state_s sys_state = 5'h01;
  dbg_port_pkg::link_cfg_s link_cfg_q;
  logic [7:0] guard_cycles_q;
  logic port_shutdown_q, access_timeout_q, system_clock_request_q;
  logic system_reset_q, user_row_program_q;
  logic [1:0] clock_select_q;
  int failures = 0;
  int n_tests = 0;
  int n;
  logic [31:0] seed = 32'h7B53;
  logic [7:0] rd, w, o;
  logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7};

  always #2.5 ref_clk = ~ref_clk;

  debugger_model u_dbg (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));

  debug_port_control_status #(.PORT_REVISION(REV), .TIMEOUT_CYCLES(16)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .phy_err(phy_err), .access_waiting(access_waiting),
    .key_urow_hit(key_hit[2]), .key_prog_hit(key_hit[1]), .key_erase_hit(key_hit[0]),
    .port_enable(port_enable), .sys_state(sys_state), .reg_rdata_q(reg_rdata_q),
    .link_cfg_q(link_cfg_q), .guard_cycles_q(guard_cycles_q),
    .port_shutdown_q(port_shutdown_q), .access_timeout_q(access_timeout_q),
    .clock_select_q(clock_select_q), .system_clock_request_q(system_clock_request_q),
    .system_reset_q(system_reset_q), .user_row_program_q(user_row_program_q));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] guard_exp(input logic [2:0] g);
    return (g == 3'h7) ? 8'h80 : (8'h80 >> g);
  endfunction

  function automatic logic [7:0] status_exp(input logic [4:0] s, input logic r);
    return {2'h0, s[4] | r, s[3:1], 1'b0, s[0]};
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    u_dbg.read_reg(a, rd);
    chk_reg(rd, exp);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic pulse_err(input logic [4:0] e);
    cyc(1);
    phy_err = e;
    cyc(1);
    phy_err = '0;
  endtask

  // a hang is cut short here
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    cyc(6);
    reset = 1'b0;
    for (n = 0; n < 16; n++)
      rd_chk(4'(n), n == 0 ? {REV, 4'h0} : n == 9 ? 8'h03 : n == 11 ? 8'h01 : 8'h00);
    chk_out(16'(guard_cycles_q), 16'h0080);
    // each phy_err source alone, then all five at once; reads clear the code
    for (n = 0; n < 5; n++)
    begin
      pulse_err(5'h10 >> n);
      rd_chk(4'h1, 8'(codes[n]));
      rd_chk(4'h1, 8'h00);
    end
    pulse_err(5'h1F);
    rd_chk(4'h1, 8'h07);
    u_dbg.write_reg(4'h2, 8'h20);
    pulse_err(5'h10);
    rd_chk(4'h1, 8'h00);
    u_dbg.write_reg(4'h3, 8'h08);
    pulse_err(5'h01);
    rd_chk(4'h1, 8'h00);
    u_dbg.write_reg(4'h3, 8'h00);
    pulse_err(5'h01);
    rd_chk(4'h1, 8'h07);
    // access layer time-out, armed then suppressed
    u_dbg.write_reg(4'h2, 8'h00);
    access_waiting = 1'b1;
    n = 0;
    while (access_timeout_q !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    // sixteen-cycle limit in this bench, so the pulse shows after 16 edges
    chk_out(16'(n), 16'h0010);
    cyc(1);
    chk_out(16'(access_timeout_q), 16'h0000);
    access_waiting = 1'b0;
    rd_chk(4'h1, 8'h03);
    u_dbg.write_reg(4'h2, 8'h10);
    access_waiting = 1'b1;
    o = 8'h00;
    repeat (30)
    begin
      cyc(1);
      o = o | {7'h0, access_timeout_q};
    end
    access_waiting = 1'b0;
    chk_out(16'(o), 16'h0000);
    // every guard code with random option bits, prompt and slow debugger
    for (n = 0; n < 8; n++)
    begin
      u_dbg.gap = n % 3;
      w = (8'(xs()) & 8'hF8) | 8'(n);
      o = 8'(xs()) & 8'hFB;
      u_dbg.write_reg(4'h2, w);
      u_dbg.write_reg(4'h3, o);
      rd_chk(4'h2, w & 8'hBF);
      rd_chk(4'h3, o & 8'h18);
      chk_out(16'(link_cfg_q), 16'({w[7], w[5:0], o[4:3]}));
      chk_out(16'(guard_cycles_q), 16'(guard_exp(3'(n))));
    end
    u_dbg.gap = 0;
    u_dbg.write_reg(4'h2, 8'h00);
    // keys, reset request, user-row session
    cyc(1);
    key_hit = 3'h7;
    cyc(1);
    key_hit = 3'h0;
    rd_chk(4'h7, 8'h38);
    u_dbg.write_reg(4'h8, 8'h59);
    chk_out(16'(system_reset_q), 16'h0001);
    rd_chk(4'h7, 8'h30);
    rd_chk(4'hB, status_exp(sys_state, 1'b1));
    u_dbg.write_reg(4'h8, 8'h00);
    chk_out(16'(system_reset_q), 16'h0000);
    u_dbg.write_reg(4'h8, 8'h12);
    chk_out(16'(system_reset_q), 16'h0000);
    rd_chk(4'h8, 8'h12);
    u_dbg.write_reg(4'h8, 8'h00);
    u_dbg.write_reg(4'hA, 8'h03);
    chk_out(16'({user_row_program_q, system_clock_request_q}), 16'h0003);
    u_dbg.write_reg(4'h7, 8'h20);
    rd_chk(4'h7, 8'h10);
    u_dbg.write_reg(4'hA, 8'h02);
    chk_out(16'({user_row_program_q, system_clock_request_q}), 16'h0000);
    sys_state = 5'h05;
    cyc(8);
    rd_chk(4'h7, 8'h00);
    rd_chk(4'hB, 8'h09);
    repeat (4)
    begin
      w = 8'(xs());
      sys_state = w[4:0];
      cyc(6);
      rd_chk(4'hB, status_exp(sys_state, 1'b0));
    end
    // faster clock selections in this scenario
    u_dbg.write_reg(4'h9, 8'h01);
    chk_out(16'(clock_select_q), 16'h0001);
    u_dbg.write_reg(4'h9, 8'h02);
    u_dbg.write_reg(4'h9, 8'h00);
    chk_out(16'(clock_select_q), 16'h0002);
    rd_chk(4'h9, 8'h02);
    // port disable wipes configuration and keys
    u_dbg.write_reg(4'h2, 8'hBF);
    u_dbg.write_reg(4'h3, 8'h18);
    u_dbg.write_reg(4'hA, 8'h01);
    key_hit = 3'h4;
    phy_err = 5'h02;
    cyc(1);
    key_hit = 3'h0;
    phy_err = '0;
    u_dbg.write_reg(4'h3, 8'h04);
    chk_out(16'({port_shutdown_q, system_clock_request_q, clock_select_q}), 16'h000B);
    chk_out(16'(link_cfg_q), 16'h0000);
    for (n = 1; n < 4; n++)
      rd_chk(4'(n), 8'h00);
    rd_chk(4'h7, 8'h00);
    cyc(1);
    port_enable = 1'b1;
    cyc(1);
    port_enable = 1'b0;
    chk_out(16'({system_clock_request_q, clock_select_q}), 16'h0007);
    // unmapped and read-only places ignore writes
    u_dbg.write_reg(4'h5, 8'hFF);
    u_dbg.write_reg(4'h0, 8'hFF);
    rd_chk(4'h5, 8'h00);
    rd_chk(4'h0, {REV, 4'h0});
    summarize();
  end
endmodule
`default_nettype wire
